// File: slb_pkg.sv
// constants and helpers shared by the serial link configuration bank
package slb_pkg;
   // register byte offsets on the configuration port
   localparam logic [7:0] SLB_OFF_CAPAB  = 8'h9c;
   localparam logic [7:0] SLB_OFF_TXCFG  = 8'ha4;
   localparam logic [7:0] SLB_OFF_RXCFG  = 8'ha8;
   localparam logic [7:0] SLB_OFF_TRAIN  = 8'hac;
   localparam logic [7:0] SLB_OFF_FREQ   = 8'hb0;
   localparam logic [7:0] SLB_OFF_TX2    = 8'hb4;
   localparam logic [7:0] SLB_OFF_RX2    = 8'hb8;
   localparam logic [7:0] SLB_OFF_TRAIN2 = 8'hbc;
   localparam logic [7:0] SLB_OFF_BIST   = 8'hc0;
   localparam logic [2:0] SLB_WIN_TAG    = 3'h5;  // 0xa0..0xbf window
   // view select codes
   localparam logic [1:0] SLB_VIEW_CFG  = 2'h0;
   localparam logic [1:0] SLB_VIEW_RXST = 2'h1;
   localparam logic [1:0] SLB_VIEW_TXST = 2'h2;
   // field positions
   localparam int SLB_VIEW_LSB   = 16;
   localparam int SLB_TXC_COMPL  = 13;
   localparam int SLB_TXC_ATTEN  = 16;
   localparam int SLB_TXC_DEEMPH = 24;
   localparam int SLB_TXC_POST   = 31;
   localparam int SLB_RXC_COMPL  = 0;
   localparam int SLB_RXC_LEVEL  = 16;
   localparam int SLB_RXC_EN     = 31;
   localparam int SLB_TRN_SCR    = 3;
   localparam int SLB_TRN_ATT    = 4;
   localparam int SLB_TRN_LPS    = 7;
   localparam int SLB_TRN_BIST   = 10;
   localparam int SLB_TRN_LOOP   = 11;
   localparam int SLB_FRQ_TOP    = 0;
   localparam int SLB_BST_OFF    = 1;
   localparam int SLB_BST_KIND   = 6;
   localparam int SLB_BST_LANE   = 8;
   localparam int SLB_BST_TALLY  = 16;
   localparam int SLB_BST_WIDTH  = 31;
   localparam int SLB_MASK_IDX   = 2;   // lane mask entry in a view store
   // reset values and writable masks
   localparam logic [31:0] SLB_CAPAB_RST = 32'hd03c_7008;
   localparam logic [31:0] SLB_CAPAB_WM  = 32'h0003_0000;
   localparam logic [31:0] SLB_TXC_RST   = 32'h0500_0000;
   localparam logic [31:0] SLB_TXC_WM    = 32'hcfe7_ffff;
   localparam logic [31:0] SLB_RXC_RST   = 32'h0000_0000;
   localparam logic [31:0] SLB_RXC_WM    = 32'hc00f_7c03;
   localparam logic [31:0] SLB_TRN_RST   = 32'h0000_0071;
   localparam logic [31:0] SLB_TRN_WM    = 32'h001f_7df8;
   localparam logic [31:0] SLB_FRQ_RST   = 32'h0000_000e;
   localparam logic [31:0] SLB_FRQ_WM    = 32'h0000_0001;
   localparam logic [31:0] SLB_BST_WM    = 32'h0000_0022;
   localparam logic [31:0] SLB_BST_RO    = 32'h8000_0000;
   // self-test view entries: ctrl, buf1, mask, inv, buf2, sel, ext, scr
   localparam logic [31:0] SLB_ST_WM [8] = '{
      32'h03ff_ffff, 32'h00ff_ffff, 32'h0003_ffff, 32'h0003_ffff,
      32'h00ff_ffff, 32'h0003_ffff, 32'hffff_ffff, 32'h0003_ffff};
   localparam logic [31:0] SLB_ST_RST [8] = '{
      32'h0000_0000, 32'h0000_0000, 32'h0000_3fff, 32'h0000_0000,
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
   // field codes
   localparam logic [2:0] SLB_TX_NORMAL = 3'h0;
   localparam logic [2:0] SLB_TX_FLOAT  = 3'h1;
   localparam logic [2:0] SLB_TX_LOW    = 3'h2;
   localparam logic [2:0] SLB_TX_HIGH   = 3'h3;
   localparam logic [2:0] SLB_TX_QUIET  = 3'h5;
   localparam logic [1:0] SLB_RX_NORMAL = 2'h0;
   localparam logic [1:0] SLB_RX_SHUT   = 2'h2;
   localparam logic [1:0] SLB_LP_RSVD   = 2'h1;
   localparam logic [1:0] SLB_ERR_NONE  = 2'h0;
   localparam logic [1:0] SLB_ERR_TRAIN = 2'h1;
   localparam logic [1:0] SLB_ERR_MISS  = 2'h2;
   localparam int SLB_TALLY_W = 11;
   localparam int SLB_LANES   = 18;

   // byte-enabled write that only touches writable bits
   function automatic logic [31:0] slb_merge(input logic [31:0] old_v,
                                             input logic [31:0] wdata,
                                             input logic [3:0]  be,
                                             input logic [31:0] wmask);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
      return (old_v & ~m) | (wdata & m);
   endfunction : slb_merge
endpackage : slb_pkg

// File: slb_view_if.sv
// access carrier between the bank and one self-test view store
interface slb_view_if;
   logic        wr;
   logic [2:0]  idx;
   logic [31:0] wdata;
   logic [3:0]  be;
   logic [31:0] rdata;
   logic [17:0] lane_mask;
   modport bank  (output wr, idx, wdata, be, input rdata, lane_mask);
   modport store (input wr, idx, wdata, be, output rdata, lane_mask);
endinterface : slb_view_if

// File: slb_view_store.sv
// storage for one self-test view (pattern, mask, inversion, scramble)
module slb_view_store #(
   parameter int ENTRIES = 8
) (
   input  wire logic   clock_i,
   input  wire logic   resetn_i,
   slb_view_if.store   vw
);
   logic [31:0] mem_r [ENTRIES];

   // one flop group per entry; reserved bits never take a write
   for (genvar e = 0; e < ENTRIES; e++) begin : g_ent
      always_ff @(posedge clock_i) begin
         if (!resetn_i) begin
            mem_r[e] <= slb_pkg::SLB_ST_RST[e];
         end else if (vw.wr && vw.idx == 3'(e)) begin
            mem_r[e] <= slb_pkg::slb_merge(mem_r[e], vw.wdata, vw.be,
                                           slb_pkg::SLB_ST_WM[e]);
         end
      end

      AST_ST_HOLD: assert property (@(posedge clock_i) disable iff (!resetn_i)
         !(vw.wr && vw.idx == 3'(e)) |=> mem_r[e] == $past(mem_r[e]))
         else $error("view entry changed without its own write");
   end

   // read is a plain index; the bank registers it
   assign vw.rdata     = mem_r[vw.idx];
   assign vw.lane_mask = mem_r[slb_pkg::SLB_MASK_IDX][17:0];
endmodule : slb_view_store

// File: slb_cfg_bank.sv
// physical layer configuration and self-test register bank
// Operation
// - two-bit view select at capability bits 17:16 picks config, rx or tx view
// - view 00 shows link config registers; 01 and 10 show self-test views
// - tx compliance: normal, float, low, high, quiet; reserved codes rejected
// - three-bit tx attenuation, zero means no attenuation
// - de-emphasis amount resets to 5; bit 31 enables post-cursor de-emphasis
// - rx compliance: 00 normal, 10 receiver off; other codes rejected
// - margining enable bit 31, level 19:16, always symmetric on the eye
// - training capability bits read ganged 1, coupling 0, block code 0
// - retry attempt limit, three bits, resets to 7
// - low-power state choice 00, 10, 11; code 01 rejected
// - bit 11 internal loopback, bit 3 scrambler, bit 10 self-test on
// - frequency extension bit 0 gives top bit of the rate code
// - extended rate support reads 7: 2.8, 3.0 and 3.2 GHz
// - second link rate fields read zero and do nothing
// - second link config registers read zero in config view
// - receiver check off: minimal training, miscompare checking suppressed
// - error kind: 00 none, 01 training, 10 miscompare
// - five-bit field captures lane of first self-test error
// - eleven-bit error tally counts errors of a self-test run
// - control bit 31 reads 1: engine is 16 bits wide
module slb_cfg_bank (
   input  wire logic        clock_i,
   input  wire logic        resetn_i,
   // configuration cycle port
   input  wire logic        cfg_req_i,
   input  wire logic        cfg_write_i,
   input  wire logic [7:0]  cfg_addr_i,
   input  wire logic [3:0]  cfg_be_i,
   input  wire logic [31:0] cfg_wdata_i,
   output logic             cfg_ack_o,
   output logic [31:0]      cfg_rdata_o,
   // self-test error reports from the link side
   input  wire logic        lnk_clk_i,
   input  wire logic        lnk_err_i,
   input  wire logic        lnk_err_train_i,
   input  wire logic [4:0]  lnk_err_lane_i,
   // controls towards the physical layer
   output logic [2:0]       tx_compliance_o,
   output logic [2:0]       tx_attenuation_o,
   output logic [3:0]       deemph_amount_o,
   output logic             postcursor_enable_o,
   output logic             receiver_shut_state_o,
   output logic             rx_timing_offset_enable_o,
   output logic [3:0]       rx_timing_offset_level_o,
   output logic             scrambler_on_o,
   output logic [2:0]       retry_attempt_limit_o,
   output logic [1:0]       low_power_state_choice_o,
   output logic             selftest_on_o,
   output logic             internal_loop_on_o,
   output logic             freq_code_top_bit_o,
   output logic             receiver_check_off_o,
   output logic [17:0]      rx_lane_mask_o,
   output logic [17:0]      tx_lane_mask_o
);
   localparam int TW = slb_pkg::SLB_TALLY_W;

   logic [31:0]   cap_r;
   logic [31:0]   tx_cfg_r;
   logic [31:0]   tx_cfg_nxt;
   logic [31:0]   rx_cfg_r;
   logic [31:0]   rx_cfg_nxt;
   logic [31:0]   trn_r;
   logic [31:0]   trn_nxt;
   logic [31:0]   frq_r;
   logic [31:0]   bst_r;
   logic [1:0]    kind_r;
   logic [1:0]    kind_nxt;
   logic [4:0]    lane_r;
   logic [4:0]    lane_nxt;
   logic [TW-1:0] tally_r;
   logic [TW-1:0] tally_nxt;
   logic [17:0]   rx_err_map_r;
   logic [17:0]   rx_err_map_nxt;
   logic          bist_d_r;
   logic [7:0]    lnk_s1_r;
   logic [7:0]    lnk_s2_r;
   logic          lnk_clk_d_r;
   logic          ack_r;
   logic [31:0]   rdata_r;
   logic [31:0]   rd_nxt;
   logic [1:0]    view;
   logic          wr;
   logic          in_win;
   logic          lnk_edge;
   logic          ev;
   logic          ev_miss;
   logic          ev_train;
   logic          ev_count;
   logic          run_start;

   slb_view_if rx_vw ();
   slb_view_if tx_vw ();

   // view select and basic access decode
   assign view   = cap_r[slb_pkg::SLB_VIEW_LSB +: 2];
   assign wr     = cfg_req_i && cfg_write_i;
   assign in_win = cfg_addr_i[7:5] == slb_pkg::SLB_WIN_TAG;

   // capability register: only the view select field is writable
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         cap_r <= slb_pkg::SLB_CAPAB_RST;
      end else if (wr && cfg_addr_i == slb_pkg::SLB_OFF_CAPAB) begin
         cap_r <= slb_pkg::slb_merge(cap_r, cfg_wdata_i, cfg_be_i,
                                     slb_pkg::SLB_CAPAB_WM);
      end
   end

   // next values; a reserved code leaves the old field in place
   always_comb begin
      tx_cfg_nxt = slb_pkg::slb_merge(tx_cfg_r, cfg_wdata_i, cfg_be_i,
                                      slb_pkg::SLB_TXC_WM);
      case (tx_cfg_nxt[slb_pkg::SLB_TXC_COMPL +: 3])
         slb_pkg::SLB_TX_NORMAL, slb_pkg::SLB_TX_FLOAT,
         slb_pkg::SLB_TX_LOW, slb_pkg::SLB_TX_HIGH,
         slb_pkg::SLB_TX_QUIET: begin
         end
         default: begin
            tx_cfg_nxt[slb_pkg::SLB_TXC_COMPL +: 3] =
               tx_cfg_r[slb_pkg::SLB_TXC_COMPL +: 3];
         end
      endcase
      rx_cfg_nxt = slb_pkg::slb_merge(rx_cfg_r, cfg_wdata_i, cfg_be_i,
                                      slb_pkg::SLB_RXC_WM);
      if (rx_cfg_nxt[slb_pkg::SLB_RXC_COMPL +: 2] != slb_pkg::SLB_RX_NORMAL
          && rx_cfg_nxt[slb_pkg::SLB_RXC_COMPL +: 2] != slb_pkg::SLB_RX_SHUT)
      begin
         rx_cfg_nxt[slb_pkg::SLB_RXC_COMPL +: 2] =
            rx_cfg_r[slb_pkg::SLB_RXC_COMPL +: 2];
      end
      trn_nxt = slb_pkg::slb_merge(trn_r, cfg_wdata_i, cfg_be_i,
                                   slb_pkg::SLB_TRN_WM);
      if (trn_nxt[slb_pkg::SLB_TRN_LPS +: 2] == slb_pkg::SLB_LP_RSVD) begin
         trn_nxt[slb_pkg::SLB_TRN_LPS +: 2] =
            trn_r[slb_pkg::SLB_TRN_LPS +: 2];
      end
   end

   // configuration-view registers take writes only while view 00 is shown
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         tx_cfg_r <= slb_pkg::SLB_TXC_RST;
         rx_cfg_r <= slb_pkg::SLB_RXC_RST;
         trn_r    <= slb_pkg::SLB_TRN_RST;
         frq_r    <= slb_pkg::SLB_FRQ_RST;
         bst_r    <= '0;
      end else if (wr && view == slb_pkg::SLB_VIEW_CFG) begin
         if (cfg_addr_i == slb_pkg::SLB_OFF_TXCFG) begin
            tx_cfg_r <= tx_cfg_nxt;
         end
         if (cfg_addr_i == slb_pkg::SLB_OFF_RXCFG) begin
            rx_cfg_r <= rx_cfg_nxt;
         end
         if (cfg_addr_i == slb_pkg::SLB_OFF_TRAIN) begin
            trn_r <= trn_nxt;
         end
         if (cfg_addr_i == slb_pkg::SLB_OFF_FREQ) begin
            frq_r <= slb_pkg::slb_merge(frq_r, cfg_wdata_i, cfg_be_i,
                                        slb_pkg::SLB_FRQ_WM);
         end
         if (cfg_addr_i == slb_pkg::SLB_OFF_BIST) begin
            bst_r <= slb_pkg::slb_merge(bst_r, cfg_wdata_i, cfg_be_i,
                                        slb_pkg::SLB_BST_WM);
         end
      end
   end

   // separate storage for each self-test view
   assign rx_vw.wr    = wr && in_win && view == slb_pkg::SLB_VIEW_RXST;
   assign rx_vw.idx   = cfg_addr_i[4:2];
   assign rx_vw.wdata = cfg_wdata_i;
   assign rx_vw.be    = cfg_be_i;
   assign tx_vw.wr    = wr && in_win && view == slb_pkg::SLB_VIEW_TXST;
   assign tx_vw.idx   = cfg_addr_i[4:2];
   assign tx_vw.wdata = cfg_wdata_i;
   assign tx_vw.be    = cfg_be_i;

   slb_view_store #(.ENTRIES(8)) u_rx_store (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .vw       (rx_vw.store)
   );

   slb_view_store #(.ENTRIES(8)) u_tx_store (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .vw       (tx_vw.store)
   );

   // link-side report pins cross into the core clock through two flops
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         lnk_s1_r    <= '0;
         lnk_s2_r    <= '0;
         lnk_clk_d_r <= 1'b0;
      end else begin
         lnk_s1_r    <= {lnk_clk_i, lnk_err_i, lnk_err_train_i,
                         lnk_err_lane_i};
         lnk_s2_r    <= lnk_s1_r;
         lnk_clk_d_r <= lnk_s2_r[7];
      end
   end

   // a report is taken at each rising link clock edge seen in the core
   assign lnk_edge  = lnk_s2_r[7] && !lnk_clk_d_r;
   assign ev        = lnk_edge && lnk_s2_r[6];
   assign ev_train  = ev && lnk_s2_r[5];
   // miscompares are dropped while receiver checking is off
   assign ev_miss   = ev && !lnk_s2_r[5]
                      && !bst_r[slb_pkg::SLB_BST_OFF];
   assign ev_count  = ev_train || ev_miss;
   assign run_start = trn_r[slb_pkg::SLB_TRN_BIST] && !bist_d_r;

   // a new run clears the status, but an error in that cycle still lands
   always_comb begin
      kind_nxt       = run_start ? slb_pkg::SLB_ERR_NONE : kind_r;
      lane_nxt       = run_start ? 5'h00 : lane_r;
      tally_nxt      = run_start ? '0 : tally_r;
      rx_err_map_nxt = run_start ? 18'h00000 : rx_err_map_r;
      if (ev_count && kind_nxt == slb_pkg::SLB_ERR_NONE) begin
         kind_nxt = ev_train ? slb_pkg::SLB_ERR_TRAIN
                             : slb_pkg::SLB_ERR_MISS;
         lane_nxt = lnk_s2_r[4:0];
      end
      if (ev_count && tally_nxt != '1) begin
         tally_nxt = tally_nxt + 1'b1;
      end
      if (ev_miss && lnk_s2_r[4:0] < 5'(slb_pkg::SLB_LANES)) begin
         rx_err_map_nxt[lnk_s2_r[4:0]] = 1'b1;
      end
   end

   // self-test status flops
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         kind_r       <= slb_pkg::SLB_ERR_NONE;
         lane_r       <= 5'h00;
         tally_r      <= '0;
         rx_err_map_r <= 18'h00000;
         bist_d_r     <= 1'b0;
      end else begin
         kind_r       <= kind_nxt;
         lane_r       <= lane_nxt;
         tally_r      <= tally_nxt;
         rx_err_map_r <= rx_err_map_nxt;
         bist_d_r     <= trn_r[slb_pkg::SLB_TRN_BIST];
      end
   end

   // read mux; unmapped offsets and reserved words read as zero
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (cfg_addr_i == slb_pkg::SLB_OFF_CAPAB) begin
         rd_nxt = cap_r;
      end else if (view == slb_pkg::SLB_VIEW_RXST && in_win) begin
         rd_nxt = rx_vw.rdata;
      end else if (view == slb_pkg::SLB_VIEW_TXST && in_win) begin
         rd_nxt = tx_vw.rdata;
      end else if (view == slb_pkg::SLB_VIEW_RXST
                   && cfg_addr_i == slb_pkg::SLB_OFF_BIST) begin
         rd_nxt = {14'h0000, rx_err_map_r};
      end else if (view == slb_pkg::SLB_VIEW_CFG) begin
         case (cfg_addr_i)
            slb_pkg::SLB_OFF_TXCFG: rd_nxt = tx_cfg_r;
            slb_pkg::SLB_OFF_RXCFG: rd_nxt = rx_cfg_r;
            slb_pkg::SLB_OFF_TRAIN: rd_nxt = trn_r;
            slb_pkg::SLB_OFF_FREQ:  rd_nxt = frq_r;
            slb_pkg::SLB_OFF_BIST: begin
               rd_nxt = bst_r | slb_pkg::SLB_BST_RO;
               rd_nxt[slb_pkg::SLB_BST_KIND +: 2]   = kind_r;
               rd_nxt[slb_pkg::SLB_BST_LANE +: 5]   = lane_r;
               rd_nxt[slb_pkg::SLB_BST_TALLY +: TW] = tally_r;
            end
            default: rd_nxt = 32'h0000_0000;
         endcase
      end
   end

   // every request is answered one cycle later
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         ack_r   <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else begin
         ack_r   <= cfg_req_i;
         rdata_r <= (cfg_req_i && !cfg_write_i) ? rd_nxt : 32'h0000_0000;
      end
   end

   assign cfg_ack_o   = ack_r;
   assign cfg_rdata_o = rdata_r;

   // physical layer controls straight from the flops
   assign tx_compliance_o           = tx_cfg_r[slb_pkg::SLB_TXC_COMPL +: 3];
   assign tx_attenuation_o          =
      tx_cfg_r[slb_pkg::SLB_TXC_ATTEN +: 3];
   assign deemph_amount_o           = tx_cfg_r[slb_pkg::SLB_TXC_DEEMPH +: 4];
   assign postcursor_enable_o       = tx_cfg_r[slb_pkg::SLB_TXC_POST];
   assign receiver_shut_state_o     =
      rx_cfg_r[slb_pkg::SLB_RXC_COMPL +: 2] == slb_pkg::SLB_RX_SHUT;
   // side bit is stored only; margin is always symmetric
   assign rx_timing_offset_enable_o = rx_cfg_r[slb_pkg::SLB_RXC_EN];
   assign rx_timing_offset_level_o  = rx_cfg_r[slb_pkg::SLB_RXC_LEVEL +: 4];
   assign scrambler_on_o            = trn_r[slb_pkg::SLB_TRN_SCR];
   assign retry_attempt_limit_o     = trn_r[slb_pkg::SLB_TRN_ATT +: 3];
   assign low_power_state_choice_o  = trn_r[slb_pkg::SLB_TRN_LPS +: 2];
   assign selftest_on_o             = trn_r[slb_pkg::SLB_TRN_BIST];
   assign internal_loop_on_o        = trn_r[slb_pkg::SLB_TRN_LOOP];
   assign freq_code_top_bit_o       = frq_r[slb_pkg::SLB_FRQ_TOP];
   assign receiver_check_off_o      = bst_r[slb_pkg::SLB_BST_OFF];
   assign rx_lane_mask_o            = rx_vw.lane_mask;
   assign tx_lane_mask_o            = tx_vw.lane_mask;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);

   AST_VIEW_TX: assert property (cfg_req_i && !cfg_write_i && cfg_addr_i ==
      slb_pkg::SLB_OFF_TXCFG && view == slb_pkg::SLB_VIEW_CFG
      |=> cfg_ack_o && cfg_rdata_o == $past(tx_cfg_r))
      else $error("config view read of tx register wrong");
   AST_TX_RSVD: assert property (wr && cfg_addr_i == slb_pkg::SLB_OFF_TXCFG
      && cfg_be_i[1] && cfg_wdata_i[15:13] == 3'h4
      |=> tx_compliance_o == $past(tx_compliance_o))
      else $error("reserved tx compliance code was stored");
   AST_DEEMPH_RST: assert property ($rose(resetn_i)
      |-> deemph_amount_o == 4'h5 && !postcursor_enable_o)
      else $error("de-emphasis amount not 5 after reset");
   AST_RX_RSVD: assert property (receiver_shut_state_o
      || rx_cfg_r[1:0] == slb_pkg::SLB_RX_NORMAL)
      else $error("rx compliance holds a reserved code");
   AST_LP_RSVD: assert property (low_power_state_choice_o
      != slb_pkg::SLB_LP_RSVD)
      else $error("low-power choice holds reserved code");
   AST_TRN_CAP: assert property (trn_r[2:0] == 3'h1)
      else $error("training capability bits changed");
   AST_FREQ_RO: assert property (frq_r[31:1] == 31'h0000_0007)
      else $error("frequency capability bits changed");
   AST_SECOND_ZERO: assert property (cfg_req_i && !cfg_write_i &&
      view == slb_pkg::SLB_VIEW_CFG && cfg_addr_i == slb_pkg::SLB_OFF_RX2
      |=> cfg_rdata_o == 32'h0000_0000)
      else $error("second link register not zero");
   AST_CHECK_OFF: assert property (ev && !lnk_s2_r[5] && receiver_check_off_o
      && !run_start |=> $stable(tally_r))
      else $error("miscompare counted while checking is off");
   AST_FIRST_LANE: assert property (ev_count && !run_start
      && kind_r == slb_pkg::SLB_ERR_NONE |=> lane_r == $past(lnk_s2_r[4:0])
      && kind_r != slb_pkg::SLB_ERR_NONE)
      else $error("first failing lane not captured");
   AST_TALLY: assert property (ev_count && !run_start && tally_r != '1
      |=> tally_r == $past(tally_r) + 1'b1)
      else $error("error tally did not advance by one");
endmodule : slb_cfg_bank

// File: slb_link_model.sv
// link-side model that sends self-test error reports on a slow clock
module slb_link_model (
   output logic       lnk_clk_o,
   output logic       err_o,
   output logic       train_o,
   output logic [4:0] lane_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // clock parked low between frames
   initial begin
      lnk_clk_o = 1'b0;
      err_o = 1'b0;
      train_o = 1'b0;
      lane_o = 5'h00;
   end
   // one 64 ns frame; data is released to its inverse after the fall
   task automatic report(input logic tr, input logic [4:0] ln);
      err_o = 1'b1;
      train_o = tr;
      lane_o = ln;
      #32 lnk_clk_o = 1'b1;
      #32 lnk_clk_o = 1'b0;
      err_o = 1'b0;
      train_o = ~tr;
      lane_o = ~ln;
   endtask : report
endmodule : slb_link_model

// File: testbench.sv
// self-checking bench for the serial link configuration bank
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i, resetn_i, cfg_req_i, cfg_write_i, cfg_ack_o, lnk_clk_i;
   logic lnk_err_i, lnk_err_train_i, postcursor_enable_o;
   logic receiver_shut_state_o, rx_timing_offset_enable_o, scrambler_on_o;
   logic selftest_on_o, internal_loop_on_o, freq_code_top_bit_o;
   logic receiver_check_off_o;
   logic [1:0] low_power_state_choice_o;
   logic [2:0] tx_compliance_o, tx_attenuation_o, retry_attempt_limit_o;
   logic [3:0] cfg_be_i, deemph_amount_o, rx_timing_offset_level_o;
   logic [4:0] lnk_err_lane_i;
   logic [7:0] cfg_addr_i;
   logic [15:0] lf;
   logic [17:0] rx_lane_mask_o, tx_lane_mask_o;
   logic [31:0] cfg_wdata_i, cfg_rdata_o, rd, n;
   logic [31:0] m [logic [7:0]];
   int n_fail, n_tests;
   slb_cfg_bank DUT (.clock_i, .resetn_i, .cfg_req_i, .cfg_write_i,
      .cfg_addr_i, .cfg_be_i, .cfg_wdata_i, .cfg_ack_o, .cfg_rdata_o,
      .lnk_clk_i, .lnk_err_i, .lnk_err_train_i, .lnk_err_lane_i,
      .tx_compliance_o, .tx_attenuation_o, .deemph_amount_o,
      .postcursor_enable_o, .receiver_shut_state_o,
      .rx_timing_offset_enable_o, .rx_timing_offset_level_o,
      .scrambler_on_o, .retry_attempt_limit_o, .low_power_state_choice_o,
      .selftest_on_o, .internal_loop_on_o, .freq_code_top_bit_o,
      .receiver_check_off_o, .rx_lane_mask_o, .tx_lane_mask_o);
   slb_link_model u_lnk (.lnk_clk_o(lnk_clk_i), .err_o(lnk_err_i),
      .train_o(lnk_err_train_i), .lane_o(lnk_err_lane_i));
   // core clock, 8 ns
   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   // watchdog at 200 us: the run needs well under that
   initial begin
      #200000;
      n_fail++;
      conclude();
   end
   function automatic logic [15:0] nx(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : nx
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch at %0t exp %h got %h", $time, e, g);
      end
   endtask : chk
   // one access; the answer is always the cycle after the request
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(negedge clock_i);
      {cfg_req_i, cfg_write_i, cfg_addr_i, cfg_wdata_i} = {1'b1, w, a, d};
      @(negedge clock_i);
      cfg_req_i = 1'b0;
      rd = cfg_rdata_o;
      chk(32'h1, {31'h0, cfg_ack_o});
   endtask : acc
   // model write: writable bits only, reserved codes keep the old field
   task automatic mw(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] k;
      k = a == 8'ha4 ? slb_pkg::SLB_TXC_WM : a == 8'ha8 ?
          slb_pkg::SLB_RXC_WM : a == 8'hac ? slb_pkg::SLB_TRN_WM :
          slb_pkg::SLB_FRQ_WM;
      n = (m[a] & ~k) | (d & k);
      if (a == 8'ha4 && n[15:13] inside {3'h4, 3'h6, 3'h7})
         n[15:13] = m[a][15:13];
      if (a == 8'ha8 && n[0]) n[1:0] = m[a][1:0];
      if (a == 8'hac && n[8:7] == 2'h1) n[8:7] = m[a][8:7];
      m[a] = n;
      acc(1'b1, a, d);
      chk({6'h0, m[8'ha4][15:13], m[8'ha4][18:16],
         m[8'ha4][27:24], m[8'ha4][31], m[8'ha8][1:0] == 2'h2,
         m[8'ha8][31], m[8'ha8][19:16], m[8'hac][3], m[8'hac][6:4],
         m[8'hac][8:7], m[8'hac][10], m[8'hac][11], m[8'hb0][0]},
         {6'h0, tx_compliance_o, tx_attenuation_o, deemph_amount_o,
         postcursor_enable_o, receiver_shut_state_o,
         rx_timing_offset_enable_o, rx_timing_offset_level_o, scrambler_on_o,
         retry_attempt_limit_o, low_power_state_choice_o, selftest_on_o,
         internal_loop_on_o,
         freq_code_top_bit_o});
   endtask : mw
   task automatic conclude();
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : conclude
   // main sequence
   initial begin
      {resetn_i, cfg_req_i, cfg_write_i, cfg_addr_i} = '0;
      {cfg_be_i, cfg_wdata_i, lf} = {4'hf, 32'h0, 16'hc426};
      m = '{8'h9c: slb_pkg::SLB_CAPAB_RST, 8'ha4: 32'h0500_0000, 8'ha8: 32'h0,
            8'hac: 32'h71, 8'hb0: 32'he, 8'hb4: 32'h0, 8'hb8: 32'h0,
            8'hbc: 32'h0, 8'hc0: 32'h8000_0000, 8'h50: 32'h0};
      repeat (12) @(posedge clock_i);
      @(negedge clock_i) resetn_i = 1'b1;
      for (int p = 0; p < 2; p++) begin
         foreach (m[a]) begin
            if (p == 1 && a inside {8'h50, 8'hb4, 8'hb8, 8'hbc})
               acc(1'b1, a, '1);
            acc(1'b0, a, 32'h0);
            chk(m[a], rd);
         end
         repeat (40) begin
            lf = nx(lf);
            mw(8'ha4 + {4'h0, lf[1:0], 2'h0}, {lf, nx(lf)});
         end
      end
      acc(1'b1, 8'h9c, 32'h0001_0000);
      acc(1'b1, 8'ha8, '1);
      acc(1'b0, 8'ha8, 32'h0);
      chk(32'h3ffff, rd);
      chk(32'h3fff, {14'h0, tx_lane_mask_o});
      chk(32'h3ffff, {14'h0, rx_lane_mask_o});
      acc(1'b1, 8'h9c, 32'h0002_0000);
      acc(1'b0, 8'ha8, 32'h0);
      chk(32'h3fff, rd);
      acc(1'b1, 8'h9c, 32'h0);
      acc(1'b0, 8'ha4, 32'h0);
      chk(m[8'ha4], rd);
      mw(8'hac, m[8'hac] & ~32'h400);
      mw(8'hac, m[8'hac] | 32'h400);
      u_lnk.report(1'b0, 5'h03);
      acc(1'b0, 8'hc0, 32'h0);
      acc(1'b0, 8'hc0, 32'h0);
      chk(32'h8001_0380, rd);
      acc(1'b1, 8'hc0, 32'h2);
      u_lnk.report(1'b0, 5'h07);
      acc(1'b0, 8'hc0, 32'h0);
      acc(1'b0, 8'hc0, 32'h0);
      chk(32'h8001_0382, rd);
      chk(32'h1, {31'h0, receiver_check_off_o});
      u_lnk.report(1'b1, 5'h09);
      acc(1'b0, 8'hc0, 32'h0);
      acc(1'b0, 8'hc0, 32'h0);
      chk(32'h8002_0382, rd);
      // receiver view lane map holds lane 3 only: lane 7 came while off
      acc(1'b1, 8'h9c, 32'h0001_0000);
      acc(1'b0, 8'hc0, 32'h0);
      chk(32'h0000_0008, rd);
      acc(1'b1, 8'h9c, 32'h0);
      // a new run clears status, then a training error is the first kind
      mw(8'hac, m[8'hac] & ~32'h400);
      mw(8'hac, m[8'hac] | 32'h400);
      u_lnk.report(1'b1, 5'h05);
      acc(1'b0, 8'hc0, 32'h0);
      chk(32'h8001_0542, rd);
      conclude();
   end
endmodule : testbench
